// ==== hw/tbs_pkg.sv ====
package tbs_pkg;

  // ****************************************************************
  // widths and counts
  // ****************************************************************
  localparam int TBS_DW = 2;
  localparam int TBS_FW = 7;
  localparam int TBS_NSCR = 11;
  localparam int TBS_FG_LSB = 4;
  localparam logic [3:0] TBS_T_IDX = 4'ha;

  // ****************************************************************
  // register codes and reset values
  // ****************************************************************
  localparam logic [3:0] TBS_RC_MAXN = 4'h9;
  localparam logic [3:0] TBS_RC_T = 4'hc;
  localparam logic [3:0] TBS_RC_AC = 4'hd;
  localparam logic [1:0] TBS_DATA_RST = 2'h0;
  localparam logic [1:0] TBS_ONES = 2'h3;

  // ****************************************************************
  // operation groups, register groups, unit modes
  // ****************************************************************
  typedef enum logic [2:0] {
    FG_ADD_MASKED = 3'b000,
    FG_OR_ADDRESS = 3'b001,
    FG_DEC_MASKED = 3'b010,
    FG_ADD_ACC = 3'b011,
    FG_AND_TEST = 3'b100,
    FG_OR_TEST = 3'b101,
    FG_XNOR_TEST = 3'b110,
    FG_TEST_ONLY = 3'b111
  } tbs_fgrp_t;

  typedef enum logic [1:0] {
    RG_ONE = 2'b00,
    RG_TWO = 2'b01,
    RG_THREE = 2'b10
  } tbs_rgrp_t;

  typedef enum logic [1:0] {
    ALU_ADD = 2'b00,
    ALU_AND = 2'b01,
    ALU_OR = 2'b10,
    ALU_XNOR = 2'b11
  } tbs_alu_op_t;

  // register group from the low four microfunction bits
  function automatic tbs_rgrp_t tbs_reg_group(input logic [3:0] code);
    if (code[3] && code[1]) begin
      return code[2] ? RG_THREE : RG_TWO;
    end
    return RG_ONE;
  endfunction

  // scratch index; any non-numbered code lands on the temp register
  function automatic logic [3:0] tbs_scratch_index(input logic [3:0] code);
    return (code <= TBS_RC_MAXN) ? code : TBS_T_IDX;
  endfunction

endpackage

// ==== hw/tbs_alu_unit.sv ====
`timescale 1ns/1ps
// ****************************************************************
// two-bit arithmetic/logic unit with look-ahead terms
// ****************************************************************
module tbs_alu_unit
  import tbs_pkg::*;
(
  input wire logic [tbs_pkg::TBS_DW-1:0] opa,
  input wire logic [tbs_pkg::TBS_DW-1:0] opb,
  input wire logic cin,
  input wire tbs_pkg::tbs_alu_op_t op,
  output logic [tbs_pkg::TBS_DW-1:0] result,
  output logic cout,
  output logic gen_x,
  output logic prop_y
);

  logic [TBS_DW:0] sum_w;
  logic [TBS_DW-1:0] gen_w;
  logic [TBS_DW-1:0] prop_w;
  logic is_add;
  logic word_or;

  // plain binary sum; decrement comes from opb of all ones
  assign sum_w = {1'b0, opa} + {1'b0, opb} + {{TBS_DW{1'b0}}, cin};
  assign gen_w = opa & opb;
  assign prop_w = opa | opb;
  assign is_add = (op == ALU_ADD);
  // carry chain reused as a word-wise or of the masked and terms
  assign word_or = cin | (|gen_w);

  // result and carry selection
  always_comb begin
    unique case (op)
      ALU_ADD: result = sum_w[TBS_DW-1:0];
      ALU_AND: result = opa & opb;
      ALU_OR: result = opa | opb;
      ALU_XNOR: result = ~(opa ^ opb);
    endcase
    cout = is_add ? sum_w[TBS_DW] : word_or;
  end

  // group generate/propagate for an outside look-ahead generator
  assign gen_x = is_add ? (gen_w[1] | (prop_w[1] & gen_w[0])) : (|gen_w);
  assign prop_y = is_add & prop_w[1] & prop_w[0];

endmodule // tbs_alu_unit

// ==== hw/tbs_processing_slice.sv ====
`timescale 1ns/1ps

module tbs_processing_slice
  import tbs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [tbs_pkg::TBS_FW-1:0] microfunction_word,
  input wire logic [tbs_pkg::TBS_DW-1:0] mem_data_in_b,
  input wire logic [tbs_pkg::TBS_DW-1:0] ext_in_b,
  input wire logic [tbs_pkg::TBS_DW-1:0] mask_in_b,
  input wire logic carry_in_b,
  input wire logic shift_right_in_b,
  input wire logic address_output_enable_b,
  input wire logic data_output_enable_b,
  output logic [tbs_pkg::TBS_DW-1:0] address_out_b,
  output logic address_out_oe,
  output logic [tbs_pkg::TBS_DW-1:0] data_out_b,
  output logic data_out_oe,
  output logic ripple_carry_out_b,
  output logic ripple_carry_out_oe,
  output logic shift_right_out_b,
  output logic shift_right_out_oe,
  output logic carry_gen_x,
  output logic carry_prop_y
);

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [TBS_DW-1:0] scratch_reg [0:TBS_NSCR-1];
  logic [TBS_DW-1:0] acc_reg;
  logic [TBS_DW-1:0] mar_reg;
  logic [TBS_DW-1:0] acc_next;
  logic [TBS_DW-1:0] mar_next;
  logic [TBS_DW-1:0] scratch_next;

  // ****************************************************************
  // microfunction decode
  // ****************************************************************
  tbs_fgrp_t fgrp;
  tbs_rgrp_t rgrp;
  logic [3:0] rcode;
  logic [3:0] scr_idx;
  logic grp_one;
  logic grp_two;
  logic grp_three;
  logic op_add_masked;
  logic op_or_address;
  logic op_dec_masked;
  logic op_test_only;
  logic op_logic;
  logic is_shift;

  // upper bits pick the operation, lower bits the registers
  assign fgrp = tbs_fgrp_t'(microfunction_word[TBS_FW-1:TBS_FG_LSB]);
  assign rcode = microfunction_word[TBS_FG_LSB-1:0];
  assign rgrp = tbs_reg_group(rcode);
  assign scr_idx = tbs_scratch_index(rcode);
  assign grp_one = (rgrp == RG_ONE);
  assign grp_two = (rgrp == RG_TWO);
  assign grp_three = (rgrp == RG_THREE);

  // operation classes
  assign op_add_masked = (fgrp == FG_ADD_MASKED);
  assign op_or_address = (fgrp == FG_OR_ADDRESS);
  assign op_dec_masked = (fgrp == FG_DEC_MASKED);
  assign op_test_only = (fgrp == FG_TEST_ONLY);
  assign op_logic = microfunction_word[TBS_FW-1];
  // shift right lives in group zero with the third register group
  assign is_shift = op_add_masked & grp_three;

  // ****************************************************************
  // pin polarity
  // ****************************************************************
  logic [TBS_DW-1:0] mem_val;
  logic [TBS_DW-1:0] ext_val;
  logic [TBS_DW-1:0] mask_val;
  logic cin_val;
  logic sri_val;

  // all bus pins are active low; the core works in true sense
  assign mem_val = ~mem_data_in_b;
  assign ext_val = ~ext_in_b;
  assign mask_val = ~mask_in_b;
  assign cin_val = ~carry_in_b;
  assign sri_val = ~shift_right_in_b;

  // ****************************************************************
  // register selection
  // ****************************************************************
  logic rn_is_acc;
  logic at_is_acc;
  logic rn_is_t;
  logic [TBS_DW-1:0] rn_val;
  logic [TBS_DW-1:0] t_val;
  logic [TBS_DW-1:0] at_val;

  // group one: code 1101 is the accumulator, 1100 the temp register
  assign rn_is_acc = grp_one & (rcode == TBS_RC_AC);
  assign rn_is_t = grp_one & (rcode == TBS_RC_T);
  // groups two and three: lowest bit picks accumulator over temp
  assign at_is_acc = rcode[0];
  assign t_val = scratch_reg[TBS_T_IDX];
  // scratch outputs reach the unit through the first operand mux
  assign rn_val = rn_is_acc ? acc_reg : scratch_reg[scr_idx];
  assign at_val = at_is_acc ? acc_reg : t_val;

  // ****************************************************************
  // operand multiplexers
  // ****************************************************************
  logic [TBS_DW-1:0] acc_masked;
  logic [TBS_DW-1:0] ext_masked;
  logic [TBS_DW-1:0] amux;
  logic [TBS_DW-1:0] bmux;
  logic [TBS_DW-1:0] alu_a;
  logic [TBS_DW-1:0] alu_b;

  // mask of all ones keeps the accumulator, all zeros drops it
  assign acc_masked = acc_reg & mask_val;
  assign ext_masked = ext_val & mask_val;
  // first operand: memory bus, scratch register or accumulator
  assign amux = grp_one ? rn_val : (grp_two ? mem_val : at_val);
  // second operand: masked input bus or masked accumulator
  assign bmux = grp_three ? ext_masked : acc_masked;

  // per-group operand shaping before the unit
  always_comb begin
    alu_a = amux;
    alu_b = bmux;
    if (op_or_address) begin
      // in register groups one and two the mask itself is the second operand, as a literal
      alu_a = grp_three ? (~at_val | mask_val) : amux;
      alu_b = grp_three ? (at_val & mask_val) : mask_val;
    end else if (op_dec_masked) begin
      // all ones as second operand makes a decrement
      alu_a = bmux;
      alu_b = TBS_ONES;
    end
  end

  // ****************************************************************
  // arithmetic/logic unit
  // ****************************************************************
  tbs_alu_op_t alu_op;
  logic [TBS_DW-1:0] alu_res;
  logic alu_cout;
  logic alu_x;
  logic alu_y;

  // low two bits of the upper groups pick and, or, xnor; test reuses and
  assign alu_op = !op_logic ? ALU_ADD :
                  (fgrp == FG_OR_TEST) ? ALU_OR :
                  (fgrp == FG_XNOR_TEST) ? ALU_XNOR : ALU_AND;

  // one two-bit unit per slice; wider words cascade slices
  tbs_alu_unit u_alu (
    .opa(alu_a),
    .opb(alu_b),
    .cin(cin_val),
    .op(alu_op),
    .result(alu_res),
    .cout(alu_cout),
    .gen_x(alu_x),
    .prop_y(alu_y)
  );

  // ****************************************************************
  // shift right path
  // ****************************************************************
  logic [TBS_DW-1:0] shift_val;
  logic shift_out;

  // with input-and-mask at zero this is a plain one-bit right shift;
  // nonzero terms give the general masked form of the same group
  assign shift_out = at_val[0] & ~ext_masked[0];
  assign shift_val[1] = sri_val | (ext_masked[1] & at_val[1]);
  assign shift_val[0] = (at_val[0] & ext_masked[0]) | at_val[1] | ext_masked[1];

  // ****************************************************************
  // destination decode
  // ****************************************************************
  logic [TBS_DW-1:0] result_val;
  logic to_rn;
  logic to_at;
  logic acc_we;
  logic scratch_we;
  logic mar_we;
  logic [3:0] scratch_widx;

  assign result_val = is_shift ? shift_val : alu_res;
  // test-only group computes carry out and writes nothing
  assign to_rn = grp_one & ~op_test_only;
  assign to_at = (grp_two | grp_three) & ~op_test_only;
  // group zero with register group one writes both register and acc
  assign acc_we = (to_rn & (rn_is_acc | op_add_masked)) | (to_at & at_is_acc);
  assign scratch_we = (to_rn & ~rn_is_acc) | (to_at & ~at_is_acc);
  assign scratch_widx = (to_rn & ~rn_is_t) ? scr_idx : TBS_T_IDX;
  // address load only in group one with register groups one or two
  assign mar_we = op_or_address & ~grp_three;

  // next values; address also serves as a device address
  assign acc_next = acc_we ? result_val : acc_reg;
  assign scratch_next = result_val;
  assign mar_next = mar_we ? (amux | mask_val) : mar_reg;

  // ****************************************************************
  // clocked state
  // ****************************************************************

  // accumulator and address register
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      acc_reg <= TBS_DATA_RST;
      mar_reg <= TBS_DATA_RST;
    end else begin
      acc_reg <= acc_next;
      mar_reg <= mar_next;
    end
  end

  // scratchpad; one write port is enough, only one target per cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < TBS_NSCR; i++) begin
        scratch_reg[i] <= TBS_DATA_RST;
      end
    end else if (scratch_we) begin
      scratch_reg[scratch_widx] <= scratch_next;
    end
  end

  // ****************************************************************
  // output pins
  // ****************************************************************

  // address and data buses: active low, driven while enable is low
  assign address_out_b = ~mar_reg;
  assign address_out_oe = ~address_output_enable_b;
  assign data_out_b = ~acc_reg;
  assign data_out_oe = ~data_output_enable_b;

  // carry out floats only while shifting right
  assign ripple_carry_out_b = ~alu_cout;
  assign ripple_carry_out_oe = ~is_shift;
  // shift out is driven only while shifting right
  assign shift_right_out_b = ~shift_out;
  assign shift_right_out_oe = is_shift;

  // look-ahead terms straight from the unit
  assign carry_gen_x = alu_x;
  assign carry_prop_y = alu_y;

endmodule // tbs_processing_slice

// ==== tb/tbs_slice_chk.sv ====
`timescale 1ns/1ps
// ****
// pin checks for the slice
// ****
module tbs_slice_chk (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [6:0] microfunction_word,
  input wire logic [1:0] mem_data_in_b,
  input wire logic [1:0] ext_in_b,
  input wire logic [1:0] mask_in_b,
  input wire logic carry_in_b,
  input wire logic address_output_enable_b,
  input wire logic data_output_enable_b,
  input wire logic [1:0] address_out_b,
  input wire logic address_out_oe,
  input wire logic [1:0] data_out_b,
  input wire logic data_out_oe,
  input wire logic ripple_carry_out_b,
  input wire logic ripple_carry_out_oe,
  input wire logic shift_right_out_b,
  input wire logic shift_right_out_oe,
  input wire logic carry_gen_x,
  input wire logic carry_prop_y
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // true-sense views; acc is read back off the data pins
  wire logic [2:0] fg = microfunction_word[6:4];
  wire logic srop = (fg == 3'h0) && (microfunction_word[3:1] == 3'h7);
  wire logic ci = !carry_in_b;
  wire logic [1:0] acc = ~data_out_b;
  wire logic [1:0] ik = ~ext_in_b & ~mask_in_b;
  wire logic [1:0] mk = ~mem_data_in_b | ~mask_in_b;
  wire logic [1:0] csa = (acc & ~mask_in_b) + 2'h3 + {1'b0, ci};
  a_addr_drive: assert property (address_out_oe == !address_output_enable_b)
    else $error("address pins enable wrong");
  a_data_drive: assert property (data_out_oe == !data_output_enable_b)
    else $error("data pins enable wrong");
  a_carry_float: assert property (ripple_carry_out_oe == !srop)
    else $error("carry out enable wrong");
  a_shift_drive: assert property (shift_right_out_oe == srop)
    else $error("shift out enable wrong");
  a_shift_bit: assert property (srop && microfunction_word[0] |-> shift_right_out_b == !(acc[0] && !ik[0]))
    else $error("shifted out bit wrong");
  a_test_hold: assert property (fg == 3'h7 |=> $stable(data_out_b) && $stable(address_out_b))
    else $error("test op altered state");
  a_and_carry: assert property (microfunction_word == 7'h4f |-> ripple_carry_out_b == !(ci || (|(acc & ik))))
    else $error("word-wise or carry wrong");
  a_look_ahead: assert property (microfunction_word == 7'h4f |-> carry_gen_x == (|(acc & ik)) && !carry_prop_y)
    else $error("cascade outputs wrong");
  a_mar_load: assert property (microfunction_word == 7'h1b |=> ~address_out_b == $past(mk))
    else $error("address register load wrong");
  a_csa_acc: assert property (microfunction_word == 7'h2b |=> acc == $past(csa))
    else $error("masked decrement wrong");
endmodule // tbs_slice_chk

// ==== tb/tbs_mem_model.sv ====
`timescale 1ns/1ps
// ****
// main memory beside the slice
// ****
module tbs_mem_model (
  input wire logic ref_clk,
  input wire logic [1:0] address_out_b,
  input wire logic address_out_oe,
  output logic [1:0] mem_data_in_b
);
  logic [1:0] junk_reg = 2'h0;
  // floating address gives a moving pattern, never a stale value
  always_ff @(posedge ref_clk) begin
    junk_reg <= junk_reg + 2'h1;
  end
  // word at address a holds a+1, active low on the bus
  assign mem_data_in_b = address_out_oe ? ~(~address_out_b + 2'h1) : junk_reg;
endmodule // tbs_mem_model

// ==== tb/tbs_processing_slice_tb.sv ====
`timescale 1ns/1ps
// ****
// slice bench
// ****
module tbs_processing_slice_tb;
  import tbs_pkg::*;
  typedef struct {int kind; logic [1:0] val; int due;} tbs_note_t;
  tbs_note_t q[$];
  logic ref_clk = 1'b0, rst_b = 1'b0, ci_b = 1'b1, li_b = 1'b1, ae_b = 1'b0, de_b = 1'b0;
  logic [6:0] word = 7'h7d;
  logic [1:0] mask_b = 2'h3, ext_b = 2'h3, acc, memory_address_register, r3;
  wire logic [1:0] mem_b, addr_b, data_b;
  wire logic a_oe, d_oe, co_b, co_oe, ro_b, ro_oe, gx, py;
  int cyc = 0, mismatches = 0, checked = 0;
  logic [6:0] ops [10] = '{7'h03, 7'h13, 7'h1b, 7'h2b, 7'h3f, 7'h43, 7'h03, 7'h4f, 7'h0f, 7'h7d};
  initial forever #10 ref_clk = ~ref_clk;
  tbs_processing_slice u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .microfunction_word(word),
    .mem_data_in_b(mem_b), .ext_in_b(ext_b), .mask_in_b(mask_b), .carry_in_b(ci_b),
    .shift_right_in_b(li_b), .address_output_enable_b(ae_b), .data_output_enable_b(de_b),
    .address_out_b(addr_b), .address_out_oe(a_oe), .data_out_b(data_b), .data_out_oe(d_oe),
    .ripple_carry_out_b(co_b), .ripple_carry_out_oe(co_oe), .shift_right_out_b(ro_b),
    .shift_right_out_oe(ro_oe), .carry_gen_x(gx), .carry_prop_y(py));
  tbs_mem_model u_mem (.ref_clk(ref_clk), .address_out_b(addr_b), .address_out_oe(a_oe), .mem_data_in_b(mem_b));
  task automatic conclude();
    if (mismatches == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic note(input int kind, input logic [1:0] val, input int lat);
    q.push_back('{kind, val, cyc + 1 + lat});
  endtask
  task automatic cmp_bus(input logic [1:0] got, input logic [1:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %b want %b", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_bus({1'b0, got}, {1'b0, exp});
  endtask
  task automatic do_reset();
    @(posedge ref_clk);
    rst_b <= 1'b0;
    // park on the test-only word so the release edge writes nothing
    word <= 7'h7d;
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    acc = 2'h0;
    memory_address_register = 2'h0;
    r3 = 2'h0;
    note(0, 2'h3, 0);
    note(1, 2'h3, 0);
  endtask
  // one microinstruction with random operands; t[2] is carry or shifted bit
  task automatic step(input logic [6:0] f);
    logic [1:0] k, i, m, ik;
    logic ci, li;
    logic [2:0] t;
    k = 2'($urandom);
    i = 2'($urandom);
    ci = 1'($urandom);
    li = 1'($urandom);
    ik = i & k;
    m = memory_address_register + 2'h1;
    @(posedge ref_clk);
    word <= f;
    mask_b <= ~k;
    ext_b <= ~i;
    ci_b <= ~ci;
    li_b <= ~li;
    de_b <= 1'($urandom);
    ae_b <= (f == 7'h1b) ? 1'b0 : 1'($urandom);
    t = {1'b0, acc};
    case (f)
      7'h03: begin
        t = r3 + (acc & k) + ci;
        r3 = t[1:0];
        acc = t[1:0];
      end
      7'h13: begin
        t = r3 + k + ci;
        memory_address_register = r3 | k;
        r3 = t[1:0];
      end
      7'h1b: begin
        t = m + k + ci;
        memory_address_register = m | k;
        acc = t[1:0];
      end
      7'h2b: begin
        t = (acc & k) + 2'h3 + ci;
        acc = t[1:0];
      end
      7'h3f: begin
        t = acc + ik + ci;
        acc = t[1:0];
      end
      7'h43: begin
        t = {ci | (|(r3 & acc & k)), r3 & acc & k};
        r3 = t[1:0];
      end
      7'h4f: begin
        t = {ci | (|(acc & ik)), acc & ik};
        acc = t[1:0];
      end
      7'h0f: begin
        t = {acc[0] & ~ik[0], li | (ik[1] & acc[1]), (acc[0] & ik[0]) | acc[1] | ik[1]};
        acc = t[1:0];
      end
      default: t = {ci | (|(acc & k)), acc};
    endcase
    note((f == 7'h0f) ? 3 : 2, {1'b0, ~t[2]}, 0);
    note(0, ~acc, 1);
    note(1, ~memory_address_register, 1);
  endtask
  // cycle count and hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc > 1000) begin
      mismatches++;
      conclude();
    end
  end
  // watcher: negedge lets every edge update settle first
  always @(negedge ref_clk) begin
    while (q.size() > 0 && q[0].due <= cyc) begin
      case (q[0].kind)
        0: cmp_bus(data_b, q[0].val);
        1: cmp_bus(addr_b, q[0].val);
        2: cmp_bit(co_b, q[0].val[0]);
        default: cmp_bit(ro_b, q[0].val[0]);
      endcase
      void'(q.pop_front());
    end
  end
  // directed pass, random mix, then a second reset mid-run
  initial begin
    void'($urandom(32'h3f4812c9));
    do_reset();
    foreach (ops[j]) step(ops[j]);
    repeat (300) step(ops[$urandom % 10]);
    do_reset();
    foreach (ops[j]) step(ops[j]);
    repeat (3) @(posedge ref_clk);
    conclude();
  end
endmodule // tbs_processing_slice_tb
bind tbs_processing_slice tbs_slice_chk u_chk (.*);
